// ---- core/eeprom_pkg.sv ----
// Shared constants, pin bundle and command states of the serial EEPROM slave.
// Assumes a single 25 MHz system clock that oversamples every serial pin.
package eeprom_pkg;

  // Instruction codes; bit 3 is don't care and is masked before compare
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_PROTECT_BITS_UPDATE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_NONE = 8'hFF;

  // Status byte layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_BP_LSB = 2;
  localparam logic [1:0] BP_RESET = 2'h0;

  localparam int MEM_DEPTH = 256;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Cycles after reset before the select history reflects the real pin
  localparam logic [1:0] SYNC_FLUSH = 2'h3;

  // Self-timed write time
  localparam int CLK_HZ = 25_000_000;
  localparam int T_WRITE_MS = 5;
  localparam int WRITE_CYCLES_DEF = T_WRITE_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } pins_s;

  localparam pins_s PINS_IDLE = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};

  typedef enum logic [4:0] {
    ST_CMD = 5'h01,
    ST_ADDR = 5'h02,
    ST_RX = 5'h04,
    ST_TX = 5'h08,
    ST_WAIT = 5'h10
  } cmd_e;

endpackage : eeprom_pkg

// ---- core/pin_sync.sv ----
// Two-flop synchroniser for the bundle of serial pins.
// Assumes the pins are asynchronous to CLK; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import eeprom_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire eeprom_pkg::pins_s d,
  output var eeprom_pkg::pins_s q
);
  pins_s meta_r;

  for (genvar i = 0; i < $bits(pins_s); i++)
  begin : g_bit
    always_ff @(posedge CLK)
    begin
      if (!RSTN)
      begin
        meta_r[i] <= PINS_IDLE[i];
        q[i] <= PINS_IDLE[i];
      end
      else
      begin
        meta_r[i] <= d[i];
        q[i] <= meta_r[i];
      end
    end
  end

endmodule : pin_sync
`default_nettype wire

// ---- core/eeprom_spi_slave.sv ----
// Serial EEPROM slave: pin logic, instruction decode, self-timed writes.
// Assumes SCK, CS_N, SI, HOLD_N, WP_N come straight from pins, slower than CLK/4.
`timescale 1ns/1ps
`default_nettype none
module eeprom_spi_slave
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE,
  output logic BUSY,
  output logic PROGRAM_ENABLE_LATCH,
  output logic STANDBY
);
  import eeprom_pkg::*;

  pins_s pin_q;
  logic sck_d_r;
  logic cs_d_r;
  logic armed_r;
  logic [1:0] live_r;
  logic tx_live_r;
  logic paused_r;
  logic selected;
  logic active;
  logic rise;
  logic fall;
  logic cs_rise;
  cmd_e state_r;
  cmd_e cmd_nxt;
  logic [2:0] bit_cnt_r;
  logic [7:0] sh_in_r;
  logic [7:0] sh_out_r;
  logic [7:0] opc_r;
  logic [7:0] opc_nxt;
  logic [7:0] addr_r;
  logic [7:0] data_r;
  logic rx_ok_r;
  logic [7:0] byte_in;
  logic [7:0] cmd;
  logic byte_done;
  logic load_en;
  logic [7:0] load_val;
  logic [7:0] rd_addr;
  logic [7:0] status;
  logic so_r;
  logic so_oe_r;
  logic busy_r;
  logic [16:0] wcnt_r;
  logic wr_sr_r;
  logic wel_r;
  logic standby_r;
  logic start_wr;
  logic wr_done;
  logic exec_wren;
  logic exec_wrdi;
  logic [1:0] bp_r;
  logic [7:0] mem [MEM_DEPTH];

  pin_sync u_sync (
    .CLK(CLK),
    .RSTN(RSTN),
    .d(pins_s'{sck: SCK, cs_n: CS_N, si: SI, hold_n: HOLD_N, wp_n: WP_N}),
    .q(pin_q)
  );

  // Edge history of the synchronised clock and select
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      sck_d_r <= pin_q.sck;
      cs_d_r <= pin_q.cs_n;
    end
  end

  // Synchroniser reset values would fake a select fall; wait until they are flushed
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      live_r <= 2'h0;
    else if (live_r != SYNC_FLUSH)
      live_r <= live_r + 2'h1;
  end

  // A falling select arms the port once after reset
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      armed_r <= 1'b0;
    else if (live_r == SYNC_FLUSH && cs_d_r && !pin_q.cs_n)
      armed_r <= 1'b1;
  end

  assign selected = armed_r && !pin_q.cs_n;
  assign cs_rise = armed_r && pin_q.cs_n && !cs_d_r;

  // Pause is only sampled while the serial clock is low
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      paused_r <= 1'b0;
    else if (!pin_q.sck)
      paused_r <= selected && !pin_q.hold_n;
  end

  assign active = selected && !paused_r;
  assign rise = active && pin_q.sck && !sck_d_r;
  assign fall = active && !pin_q.sck && sck_d_r;
  assign byte_in = {sh_in_r[6:0], pin_q.si};
  assign cmd = byte_in & OP_MASK;
  assign byte_done = rise && (bit_cnt_r == LAST_BIT);
  assign status = {4'h0, bp_r, wel_r, busy_r};

  // Opcode decode, with protect and enable checks
  always_comb
  begin
    cmd_nxt = ST_WAIT;
    opc_nxt = OP_NONE;
    if (busy_r)
    begin
      if (cmd == OP_RDSR)
      begin
        cmd_nxt = ST_TX;
        opc_nxt = cmd;
      end
    end
    else
    begin
      case (cmd)
        OP_WREN, OP_WRDI:
          opc_nxt = cmd;
        OP_RDSR:
        begin
          cmd_nxt = ST_TX;
          opc_nxt = cmd;
        end
        OP_READ:
        begin
          cmd_nxt = ST_ADDR;
          opc_nxt = cmd;
        end
        OP_WRITE, OP_PROTECT_BITS_UPDATE:
        begin
          if (wel_r && pin_q.wp_n)
          begin
            cmd_nxt = (cmd == OP_WRITE) ? ST_ADDR : ST_RX;
            opc_nxt = cmd;
          end
        end
        default:
          opc_nxt = OP_NONE;
      endcase
    end
  end

  // Input shifter and instruction sequencing
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      state_r <= ST_CMD;
      bit_cnt_r <= 3'h0;
      sh_in_r <= 8'h00;
      opc_r <= OP_NONE;
      addr_r <= 8'h00;
      data_r <= 8'h00;
      rx_ok_r <= 1'b0;
    end
    else if (!selected)
    begin
      state_r <= ST_CMD;
      bit_cnt_r <= 3'h0;
      rx_ok_r <= 1'b0;
    end
    else if (rise)
    begin
      sh_in_r <= byte_in;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_ok_r <= 1'b0;
      if (byte_done)
      begin
        case (state_r)
          ST_CMD:
          begin
            state_r <= cmd_nxt;
            opc_r <= opc_nxt;
            rx_ok_r <= (cmd_nxt == ST_WAIT);
          end
          ST_ADDR:
          begin
            addr_r <= (opc_r == OP_READ) ? byte_in + 8'h01 : byte_in;
            state_r <= (opc_r == OP_READ) ? ST_TX : ST_RX;
          end
          ST_RX:
          begin
            data_r <= byte_in;
            rx_ok_r <= 1'b1;
            state_r <= ST_WAIT;
          end
          ST_TX:
          begin
            if (opc_r == OP_READ)
              addr_r <= addr_r + 8'h01;
          end
          default:
            state_r <= ST_WAIT;
        endcase
      end
    end
  end

  // Byte to load into the output shifter at a byte boundary
  always_comb
  begin
    rd_addr = (state_r == ST_ADDR) ? byte_in : addr_r;
    load_en = 1'b0;
    load_val = mem[rd_addr];
    if (byte_done)
    begin
      case (state_r)
        ST_CMD:
          load_en = (cmd_nxt == ST_TX);
        ST_ADDR:
          load_en = (opc_r == OP_READ);
        ST_TX:
          load_en = 1'b1;
        default:
          load_en = 1'b0;
      endcase
      if ((state_r == ST_CMD && cmd_nxt == ST_TX) || (state_r == ST_TX && opc_r == OP_RDSR))
        load_val = status;
    end
  end

  // Output shifter moves on falling serial clock edges
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sh_out_r <= 8'h00;
      so_r <= 1'b0;
    end
    else if (load_en)
      sh_out_r <= load_val;
    else if (fall)
    begin
      so_r <= sh_out_r[7];
      sh_out_r <= {sh_out_r[6:0], 1'b0};
    end
  end

  // Drive returns after a pause once shifting has begun in this frame
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      so_oe_r <= 1'b0;
      tx_live_r <= 1'b0;
    end
    else if (!selected)
    begin
      so_oe_r <= 1'b0;
      tx_live_r <= 1'b0;
    end
    else if (paused_r)
      so_oe_r <= 1'b0;
    else if (fall && state_r == ST_TX)
    begin
      so_oe_r <= 1'b1;
      tx_live_r <= 1'b1;
    end
    else if (tx_live_r)
      so_oe_r <= 1'b1;
  end

  assign exec_wren = cs_rise && rx_ok_r && opc_r == OP_WREN;
  assign exec_wrdi = cs_rise && rx_ok_r && opc_r == OP_WRDI;
  assign start_wr = cs_rise && rx_ok_r && !busy_r && wel_r && pin_q.wp_n
    && (opc_r == OP_WRITE || opc_r == OP_PROTECT_BITS_UPDATE);
  assign wr_done = busy_r && wcnt_r == 17'h0_0000;

  // Self-timed write; protect is not looked at once it runs
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      busy_r <= 1'b0;
      wcnt_r <= 17'h0_0000;
      wr_sr_r <= 1'b0;
    end
    else if (start_wr)
    begin
      busy_r <= 1'b1;
      wcnt_r <= 17'(WRITE_CYCLES - 1);
      wr_sr_r <= (opc_r == OP_PROTECT_BITS_UPDATE);
    end
    else if (wr_done)
      busy_r <= 1'b0;
    else if (busy_r)
      wcnt_r <= wcnt_r - 17'h0_0001;
  end

  // Block-protect bits take their new value at completion
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      bp_r <= BP_RESET;
    else if (wr_done && wr_sr_r)
      bp_r <= data_r[STAT_BP_LSB +: 2];
  end

  always_ff @(posedge CLK)
  begin
    if (wr_done && !wr_sr_r)
      mem[addr_r] <= data_r;
  end

  // Program enable latch; protect low wins over everything
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      wel_r <= 1'b0;
    else if (!pin_q.wp_n)
      wel_r <= 1'b0;
    else if (wr_done || exec_wrdi)
      wel_r <= 1'b0;
    else if (exec_wren)
      wel_r <= 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      standby_r <= 1'b1;
    else
      standby_r <= !selected && !busy_r;
  end

  assign SO = so_r;
  assign SO_OE = so_oe_r;
  assign BUSY = busy_r;
  assign PROGRAM_ENABLE_LATCH = wel_r;
  assign STANDBY = standby_r;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence s_write_req;
    cs_rise && rx_ok_r && !busy_r && (opc_r == OP_WRITE || opc_r == OP_PROTECT_BITS_UPDATE);
  endsequence

  sequence s_busy_run;
    busy_r [*8];
  endsequence

  AST_SO_AFTER_FALL: assert property ($changed(so_r) |-> $past(fall))
    else $error("serial out changed without a falling clock edge");
  AST_SAMPLE_RISE: assert property (rise && bit_cnt_r != LAST_BIT |=> sh_in_r[0] == $past(pin_q.si))
    else $error("serial in not sampled on rising edge");
  AST_DESELECT_HIZ: assert property (pin_q.cs_n |=> !so_oe_r)
    else $error("serial out driven while deselected");
  AST_STANDBY: assert property (pin_q.cs_n && !busy_r |=> standby_r)
    else $error("standby not entered while deselected and idle");
  AST_ARM_FIRST: assert property (!armed_r |-> !rise && !so_oe_r)
    else $error("serial activity accepted before first select");
  AST_PAUSE_FREEZE: assert property (paused_r |=> $stable(bit_cnt_r) && $stable(state_r))
    else $error("transfer moved while paused");
  AST_PAUSE_HIZ: assert property (paused_r |=> !so_oe_r)
    else $error("serial out driven while paused");
  AST_PROTECT_REFUSE: assert property (byte_done && state_r == ST_CMD && !pin_q.wp_n
    && (cmd == OP_WRITE || cmd == OP_PROTECT_BITS_UPDATE) |=> state_r == ST_WAIT && opc_r == OP_NONE)
    else $error("write accepted with protect low");
  AST_BUSY_HOLDS: assert property (s_write_req and (wel_r && pin_q.wp_n) |=> s_busy_run)
    else $error("write cycle cut short");
  AST_WEL_CLEAR: assert property (!pin_q.wp_n |=> !wel_r)
    else $error("enable latch not cleared by protect");
  AST_BUSY_FLAG: assert property ($fell(busy_r) |-> $past(wcnt_r) == 17'h0_0000)
    else $error("busy dropped before write time elapsed");
  AST_WEL_REFUSE: assert property (s_write_req and !wel_r |=> !busy_r)
    else $error("write started with enable latch clear");
  AST_PAUSE_SCK_LOW: assert property ($changed(paused_r) |-> !$past(pin_q.sck))
    else $error("pause changed while serial clock high");

endmodule : eeprom_spi_slave
`default_nettype wire

// ---- bench/spi_host.sv ----
// Behavioural host controller driving the serial EEPROM pins in mode 0.
// Assumes CLK is the bench clock; pins change only by non-blocking update at its rising edge.
`timescale 1ns/1ps
`default_nettype none
module spi_host
  import eeprom_pkg::*;
(
  input wire logic CLK,
  input wire logic SO,
  input wire logic SO_OE,
  output var eeprom_pkg::pins_s PINS
);
  logic so_last = 1'b0;
  logic line;
  logic hold_oe = 1'b0;
  logic so_moved = 1'b0;
  // A released data line shows a pattern that changes every cycle
  assign line = SO_OE ? SO : ~so_last;
  always @(posedge CLK) so_last <= line;
  // Powers up with select already low, so no falling edge has been seen yet
  initial
  begin
    PINS = PINS_IDLE;
    PINS.cs_n = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask : tick
  task automatic sel(input logic lvl);
    tick(4);
    PINS.cs_n <= lvl;
    tick(6);
  endtask : sel
  task automatic set_wp(input logic lvl);
    PINS.wp_n <= lvl;
    tick(6);
  endtask : set_wp
  task automatic byte_x(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (i == hold_at)
      begin
        tick(4);
        PINS.hold_n <= 1'b0;
        tick(6);
        hold_oe = SO_OE;
        PINS.si <= ~tx[i];
        PINS.sck <= 1'b1;
        tick(4);
        PINS.sck <= 1'b0;
        tick(4);
        PINS.hold_n <= 1'b1;
      end
      PINS.si <= tx[i];
      tick(4);
      PINS.sck <= 1'b1;
      tick(2);
      rx[i] = line;
      tick(2);
      if (SO_OE && line !== rx[i])
        so_moved = 1'b1;
      PINS.sck <= 1'b0;
    end
  endtask : byte_x
endmodule : spi_host
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the serial EEPROM slave, driven through the host model.
// Assumes a 25 MHz clock and a shortened self-timed write.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eeprom_pkg::*;
  localparam int WR_CYC = 400;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  pins_s pins;
  logic sck, cs_n, si, hold_n, wp_n;
  logic so, so_oe, busy, program_enable_latch, standby;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  spi_host u_spi_host (.CLK(clk), .SO(so), .SO_OE(so_oe), .PINS(pins));
  assign {sck, cs_n, si, hold_n, wp_n} = pins;
  eeprom_spi_slave #(.WRITE_CYCLES(WR_CYC)) u_eeprom_spi_slave (
    .CLK(clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .SI(si),
    .HOLD_N(hold_n), .WP_N(wp_n), .SO(so), .SO_OE(so_oe), .BUSY(busy),
    .PROGRAM_ENABLE_LATCH(program_enable_latch), .STANDBY(standby));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic frame(input logic [23:0] tx, input int nb, input int hold_at,
                       output logic [7:0] rx);
    u_spi_host.sel(1'b0);
    for (int k = 0; k < nb; k++)
      u_spi_host.byte_x(tx[23 - 8 * k -: 8], (k == nb - 1) ? hold_at : 8, rx);
    u_spi_host.sel(1'b1);
  endtask : frame
  task automatic wait_idle;
    for (int n = 0; n < 2 * WR_CYC && busy !== 1'b0; n++)
      @(posedge clk);
    check({7'h0, busy}, 8'h00, "busy after write");
  endtask : wait_idle
  task automatic t_reset_arm;
    logic [7:0] rx;
    check({4'h0, so_oe, busy, program_enable_latch, standby}, 8'h01, "reset outputs");
    rstn <= 1'b1;
    u_spi_host.byte_x(OP_WREN, 8, rx);
    u_spi_host.sel(1'b1);
    check({7'h0, program_enable_latch}, 8'h00, "enable before arming");
    frame({OP_WREN, 16'h0}, 1, 8, rx);
    check({7'h0, program_enable_latch}, 8'h01, "enable latch set");
    frame({OP_WRDI, 16'h0}, 1, 8, rx);
    check({7'h0, program_enable_latch}, 8'h00, "enable latch cleared");
    frame({OP_WREN, 16'h0}, 1, 8, rx);
  endtask : t_reset_arm
  task automatic t_rdsr;
    logic [7:0] rx;
    u_spi_host.sel(1'b0);
    u_spi_host.byte_x(OP_RDSR, 8, rx);
    u_spi_host.byte_x(8'hFF, 8, rx);
    check(rx, 8'h02, "status read");
    check({6'h0, so_oe, standby}, 8'h02, "selected outputs");
    u_spi_host.sel(1'b1);
    check({6'h0, so_oe, standby}, 8'h01, "deselected outputs");
    check({7'h0, u_spi_host.so_moved}, 8'h00, "out bit moved in high phase");
  endtask : t_rdsr
  task automatic t_write;
    logic [7:0] rx;
    frame({OP_WRITE, 8'h35, 8'hA5}, 3, 8, rx);
    check({6'h0, busy, standby}, 8'h02, "busy after write frame");
    u_spi_host.set_wp(1'b0);
    u_spi_host.set_wp(1'b1);
    frame({OP_RDSR, 8'hFF, 8'h00}, 2, 8, rx);
    check({7'h0, rx[STAT_BUSY_BIT]}, 8'h01, "busy bit during write");
    wait_idle();
    frame({OP_READ, 8'h35, 8'hFF}, 3, 8, rx);
    check(rx, 8'hA5, "written byte");
    frame({OP_WREN, 16'h0}, 1, 8, rx);
    frame({OP_PROTECT_BITS_UPDATE, 8'h0C, 8'h00}, 2, 8, rx);
    wait_idle();
    frame({OP_RDSR, 8'hFF, 8'h00}, 2, 8, rx);
    check(rx, 8'h0C, "protect bits stored");
  endtask : t_write
  task automatic t_protect;
    logic [7:0] rx;
    frame({OP_WREN, 16'h0}, 1, 8, rx);
    u_spi_host.set_wp(1'b0);
    check({7'h0, program_enable_latch}, 8'h00, "protect clears latch");
    frame({OP_WREN, 16'h0}, 1, 8, rx);
    frame({OP_WRITE, 8'h35, 8'h5A}, 3, 8, rx);
    check({6'h0, program_enable_latch, busy}, 8'h00, "write under protect");
    u_spi_host.set_wp(1'b1);
    frame({OP_WRITE, 8'h35, 8'h5A}, 3, 8, rx);
    check({7'h0, busy}, 8'h00, "write without latch");
  endtask : t_protect
  task automatic t_hold;
    logic [7:0] rx;
    frame({OP_READ, 8'h35, 8'hFF}, 3, 4, rx);
    check(rx, 8'hA5, "read across pause");
    check({7'h0, u_spi_host.hold_oe}, 8'h00, "out enable in pause");
    frame({OP_READ, 8'h35, 8'hFF}, 3, 0, rx);
    check(rx, 8'hA5, "pause before last bit");
  endtask : t_hold
  initial
  begin
    repeat (6) @(posedge clk);
    t_reset_arm();
    t_rdsr();
    t_write();
    t_protect();
    t_hold();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
